// File: verilog/rpfg_pkg.sv
/*
 * Shared constants, state encodings and carrier structs of the repeater
 * port fault guard.
 * Assumes one 250 MHz clock and a 1000 Mb/s port, so one bit time is 1 ns.
 */
package rpfg_pkg;

    // ********************************
    // timing base
    // ********************************
    localparam int BT_PS = 1000;
    localparam int CLK_PS = 4000;

    // least time: round up, never below one cycle
    function automatic int cyc_up(input int bt);
        int c;
        c = (bt * BT_PS + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    // longest time: round down, never below one cycle
    function automatic int cyc_dn(input int bt);
        int c;
        c = (bt * BT_PS) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_dn

    // ********************************
    // register map
    // ********************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_COLL = 8'h10;

    localparam int CTRL_EN = 0;
    localparam logic CTRL_EN_RST = 1'b1;

    localparam int EV_W = 4;
    localparam int EV_UNSTABLE = 0;
    localparam int EV_PART = 1;
    localparam int EV_JAB = 2;
    localparam int EV_RATE = 3;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;

    localparam int ST_UNSTABLE = 0;
    localparam int ST_PART = 1;
    localparam int ST_JAB = 2;
    localparam int ST_RATE_OK = 3;
    localparam int ST_FCE_LSB = 8;
    localparam int EVCNT_W = 8;

    // ********************************
    // state encodings
    // ********************************
    typedef enum logic [1:0] {
        CI_STABLE = 2'b00,
        CI_QUIET = 2'b01,
        CI_ARMED = 2'b10,
        CI_VALID = 2'b11
    } rpfg_ci_t;

    typedef enum logic [1:0] {
        RT_IDLE = 2'b00,
        RT_RX = 2'b01,
        RT_JAB = 2'b10
    } rpfg_rt_t;

    typedef enum logic [1:0] {
        PT_CLEAR = 2'b00,
        PT_PART = 2'b01,
        PT_WATCH = 2'b10
    } rpfg_pt_t;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic crs;
        logic false_carrier;
        logic rate_ok;
    } rpfg_pins_t;

    typedef struct packed {
        logic tx_active;
        logic collision;
    } rpfg_core_t;

    typedef struct packed {
        logic rx_pass;
        logic tx_pass;
        logic jam;
    } rpfg_gate_t;

endpackage : rpfg_pkg

// File: verilog/rpfg_port_guard.sv
/*
 * One repeater port's fault guard: carrier integrity monitor, receive
 * timer (overlong reception) and partition machine, with a small register
 * port and a level interrupt.
 * Assumes PHY status arrives asynchronously on pins, core status arrives on
 * clk, and the shared repeater core applies the gates it receives.
 */
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module rpfg_port_guard #(
    parameter logic [7:0] false_carrier_event_limit = 8'h10,
    parameter logic [7:0] collision_event_limit = 8'h40,
    parameter int FALSE_CARRIER_BT = 2048,
    parameter int IPG_BT = 96,
    parameter int QUIET_BT = 2048,
    parameter int VALID_CARRIER_BT = 512,
    parameter int JABBER_BT = 80000,
    parameter int NO_COLLISION_BT = 4096,
    parameter int CNT_W = 24
) (
    input wire logic clk, // 250 MHz
    input wire logic rst_n, // async, power-up reset
    input wire rpfg_pkg::rpfg_pins_t pins, // PHY status pins
    input wire rpfg_pkg::rpfg_core_t core, // core status, on clk
    output rpfg_pkg::rpfg_gate_t gate, // gates toward the core
    input wire logic [rpfg_pkg::ADDR_W-1:0] addr, // register address
    input wire logic [rpfg_pkg::DATA_W-1:0] wr_data, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [rpfg_pkg::DATA_W-1:0] rd_data, // read data, next cycle
    output logic irq // level interrupt
);

    localparam logic [CNT_W-1:0] FC_CYC = CNT_W'(rpfg_pkg::cyc_up(FALSE_CARRIER_BT));
    localparam logic [CNT_W-1:0] JAM_CYC = CNT_W'(rpfg_pkg::cyc_dn(FALSE_CARRIER_BT));
    localparam logic [CNT_W-1:0] IPG_CYC = CNT_W'(rpfg_pkg::cyc_up(IPG_BT));
    localparam logic [CNT_W-1:0] QUIET_CYC = CNT_W'(rpfg_pkg::cyc_up(IPG_BT + QUIET_BT));
    localparam logic [CNT_W-1:0] VC_CYC = CNT_W'(rpfg_pkg::cyc_up(VALID_CARRIER_BT));
    localparam logic [CNT_W-1:0] JAB_CYC = CNT_W'(rpfg_pkg::cyc_up(JABBER_BT));
    localparam logic [CNT_W-1:0] NC_CYC = CNT_W'(rpfg_pkg::cyc_up(NO_COLLISION_BT));
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [7:0] EVCNT_MAX = 8'hFF;

    // ********************************
    // pin synchronisers
    // ********************************
    rpfg_pkg::rpfg_pins_t s1_r, s2_r, s3_r, pin_r;
    logic fc_prev_r, vc_prev_r, crs_prev_r, tx_prev_r, rate_prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // accept a change once stages two and three agree
            pin_r <= ((s2_r ~^ s3_r) & s3_r) | (~(s2_r ~^ s3_r) & pin_r);
        end
    end

    logic crs, fc, valid, activity, rate_ok;
    assign crs = pin_r.crs;
    assign fc = pin_r.crs & pin_r.false_carrier;
    assign valid = pin_r.crs & ~pin_r.false_carrier;
    assign activity = pin_r.crs | core.tx_active;
    assign rate_ok = pin_r.rate_ok;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fc_prev_r <= 1'b0;
            vc_prev_r <= 1'b0;
            crs_prev_r <= 1'b0;
            tx_prev_r <= 1'b0;
            rate_prev_r <= 1'b0;
        end else begin
            fc_prev_r <= fc;
            vc_prev_r <= valid;
            crs_prev_r <= crs;
            tx_prev_r <= core.tx_active;
            rate_prev_r <= rate_ok;
        end
    end

    logic fc_rise, vc_rise, tx_end, rx_end;
    assign fc_rise = fc & ~fc_prev_r;
    assign vc_rise = valid & ~vc_prev_r;
    assign tx_end = tx_prev_r & ~core.tx_active;
    assign rx_end = crs_prev_r & ~crs;

    // ********************************
    // false carrier tracking
    // ********************************
    logic [CNT_W-1:0] fc_len_r;
    logic [7:0] fce_cnt_r;
    rpfg_pkg::rpfg_ci_t ci_r;
    logic [CNT_W-1:0] ci_cnt_r;
    logic fce_hit, fc_over, ci_enter_stable;

    assign fce_hit = (fce_cnt_r >= false_carrier_event_limit);
    assign fc_over = fc & (fc_len_r >= FC_CYC);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fc_len_r <= '0;
        end else if (!fc) begin
            fc_len_r <= '0;
        end else if (fc_len_r != CNT_MAX) begin
            fc_len_r <= fc_len_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fce_cnt_r <= '0;
        end else if (vc_rise || ci_enter_stable) begin
            fce_cnt_r <= '0;
        end else if (fc_rise && fce_cnt_r != EVCNT_MAX) begin
            fce_cnt_r <= fce_cnt_r + 1'b1;
        end
    end

    // ********************************
    // carrier integrity monitor
    // ********************************
    assign ci_enter_stable = ((ci_r == rpfg_pkg::CI_ARMED) && !activity && ci_cnt_r >= QUIET_CYC) ||
                             ((ci_r == rpfg_pkg::CI_VALID) && valid && !core.tx_active && ci_cnt_r >= VC_CYC);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ci_r <= rpfg_pkg::CI_QUIET;
            ci_cnt_r <= '0;
        end else begin
            case (ci_r)
                rpfg_pkg::CI_STABLE: begin
                    // count limit or overlong false carrier
                    if (fce_hit || fc_over) begin
                        ci_r <= rpfg_pkg::CI_QUIET;
                        ci_cnt_r <= '0;
                    end
                end
                rpfg_pkg::CI_QUIET: begin
                    if (activity) begin
                        ci_cnt_r <= '0;
                    end else begin
                        ci_cnt_r <= ci_cnt_r + 1'b1;
                        if (ci_cnt_r >= IPG_CYC) begin
                            ci_r <= rpfg_pkg::CI_ARMED;
                        end
                    end
                end
                rpfg_pkg::CI_ARMED: begin
                    // idle seen, wait for quiet or valid carrier
                    if (ci_enter_stable) begin
                        ci_r <= rpfg_pkg::CI_STABLE;
                        ci_cnt_r <= '0;
                    end else if (valid && !core.tx_active) begin
                        ci_r <= rpfg_pkg::CI_VALID;
                        ci_cnt_r <= '0;
                    end else if (activity) begin
                        ci_r <= rpfg_pkg::CI_QUIET;
                        ci_cnt_r <= '0;
                    end else begin
                        ci_cnt_r <= ci_cnt_r + 1'b1;
                    end
                end
                rpfg_pkg::CI_VALID: begin
                    if (ci_enter_stable) begin
                        ci_r <= rpfg_pkg::CI_STABLE;
                        ci_cnt_r <= '0;
                    end else if (valid && !core.tx_active) begin
                        ci_cnt_r <= ci_cnt_r + 1'b1;
                    end else begin
                        ci_r <= rpfg_pkg::CI_QUIET;
                        ci_cnt_r <= '0;
                    end
                end
                default: begin
                    ci_r <= rpfg_pkg::CI_QUIET;
                    ci_cnt_r <= '0;
                end
            endcase
        end
    end

    // ********************************
    // receive timer
    // ********************************
    rpfg_pkg::rpfg_rt_t rt_r;
    logic [CNT_W-1:0] rx_len_r;
    logic rx_col_r, tx_col_r, jab_hit, jab_col;

    assign jab_hit = (rt_r == rpfg_pkg::RT_RX) && crs && (rx_len_r >= JAB_CYC);
    assign jab_col = jab_hit && (rx_col_r || core.collision);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_col_r <= 1'b0;
            tx_col_r <= 1'b0;
        end else begin
            // held through the falling edge of each activity
            rx_col_r <= crs ? (rx_col_r | core.collision) : 1'b0;
            tx_col_r <= core.tx_active ? (tx_col_r | core.collision) : 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rt_r <= rpfg_pkg::RT_IDLE;
            rx_len_r <= '0;
        end else begin
            case (rt_r)
                rpfg_pkg::RT_IDLE: begin
                    rx_len_r <= '0;
                    if (crs) begin
                        rt_r <= rpfg_pkg::RT_RX;
                    end
                end
                rpfg_pkg::RT_RX: begin
                    if (!crs) begin
                        rt_r <= rpfg_pkg::RT_IDLE;
                    end else if (jab_hit) begin
                        rt_r <= rpfg_pkg::RT_JAB;
                    end else begin
                        rx_len_r <= rx_len_r + 1'b1;
                    end
                end
                rpfg_pkg::RT_JAB: begin
                    if (!crs) begin
                        rt_r <= rpfg_pkg::RT_IDLE;
                    end
                end
                default: begin
                    rt_r <= rpfg_pkg::RT_IDLE;
                end
            endcase
        end
    end

    // ********************************
    // partition
    // ********************************
    rpfg_pkg::rpfg_pt_t pt_r;
    logic [CNT_W-1:0] pt_cnt_r;
    logic [7:0] coll_cnt_r;
    logic pt_release, pt_enter;

    assign pt_release = (pt_r == rpfg_pkg::PT_WATCH) && activity && !core.collision && (pt_cnt_r >= NC_CYC);
    assign pt_enter = (pt_r == rpfg_pkg::PT_CLEAR) && ((coll_cnt_r >= collision_event_limit) || jab_col);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coll_cnt_r <= '0;
        end else if (pt_release) begin
            coll_cnt_r <= '0;
        end else if (tx_end && tx_col_r) begin
            if (coll_cnt_r != EVCNT_MAX) begin
                coll_cnt_r <= coll_cnt_r + 1'b1;
            end
        end else if ((tx_end && !tx_col_r) || (rx_end && !rx_col_r)) begin
            coll_cnt_r <= '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pt_r <= rpfg_pkg::PT_CLEAR;
            pt_cnt_r <= '0;
        end else begin
            case (pt_r)
                rpfg_pkg::PT_CLEAR: begin
                    pt_cnt_r <= '0;
                    if (pt_enter) begin
                        pt_r <= rpfg_pkg::PT_PART;
                    end
                end
                rpfg_pkg::PT_PART: begin
                    pt_cnt_r <= '0;
                    if (activity && !core.collision) begin
                        pt_r <= rpfg_pkg::PT_WATCH;
                    end
                end
                rpfg_pkg::PT_WATCH: begin
                    if (pt_release) begin
                        pt_r <= rpfg_pkg::PT_CLEAR;
                    end else if (core.collision || !activity) begin
                        pt_r <= rpfg_pkg::PT_PART;
                    end else begin
                        pt_cnt_r <= pt_cnt_r + 1'b1;
                    end
                end
                default: begin
                    pt_r <= rpfg_pkg::PT_CLEAR;
                end
            endcase
        end
    end

    // ********************************
    // gates toward the core
    // ********************************
    logic ctrl_en_r;
    logic unstable, parted, jabbing;
    assign unstable = (ci_r != rpfg_pkg::CI_STABLE);
    assign parted = (pt_r != rpfg_pkg::PT_CLEAR);
    assign jabbing = (rt_r == rpfg_pkg::RT_JAB);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate <= '0;
        end else begin
            gate.rx_pass <= ctrl_en_r & ~unstable & ~parted & ~jabbing & rate_ok;
            gate.tx_pass <= ctrl_en_r & ~unstable & ~jabbing;
            gate.jam <= ctrl_en_r & fc & (fc_len_r < JAM_CYC) & ~unstable & ~jabbing;
        end
    end

    // ********************************
    // registers and interrupt
    // ********************************
    logic [rpfg_pkg::EV_W-1:0] ev_r, mask_r, ev_set;
    logic ev_rd;

    assign ev_set[rpfg_pkg::EV_UNSTABLE] = (ci_r == rpfg_pkg::CI_STABLE) && (fce_hit || fc_over);
    assign ev_set[rpfg_pkg::EV_PART] = pt_enter;
    assign ev_set[rpfg_pkg::EV_JAB] = jab_hit;
    assign ev_set[rpfg_pkg::EV_RATE] = rate_prev_r & ~rate_ok;
    assign ev_rd = rd_en && (addr == rpfg_pkg::ADDR_EVENT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_en_r <= rpfg_pkg::CTRL_EN_RST;
            mask_r <= rpfg_pkg::MASK_RST;
        end else if (wr_en) begin
            if (addr == rpfg_pkg::ADDR_CTRL) begin
                ctrl_en_r <= wr_data[rpfg_pkg::CTRL_EN];
            end else if (addr == rpfg_pkg::ADDR_MASK) begin
                mask_r <= wr_data[rpfg_pkg::EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_r <= '0;
            irq <= 1'b0;
        end else begin
            // set wins over read-clear
            ev_r <= (ev_rd ? '0 : ev_r) | ev_set;
            irq <= |(ev_r & mask_r);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= '0;
            if (rd_en) begin
                if (addr == rpfg_pkg::ADDR_CTRL) begin
                    rd_data[rpfg_pkg::CTRL_EN] <= ctrl_en_r;
                end else if (addr == rpfg_pkg::ADDR_STATE) begin
                    rd_data[rpfg_pkg::ST_UNSTABLE] <= unstable;
                    rd_data[rpfg_pkg::ST_PART] <= parted;
                    rd_data[rpfg_pkg::ST_JAB] <= jabbing;
                    rd_data[rpfg_pkg::ST_RATE_OK] <= rate_ok;
                    rd_data[rpfg_pkg::ST_FCE_LSB +: rpfg_pkg::EVCNT_W] <= fce_cnt_r;
                end else if (addr == rpfg_pkg::ADDR_EVENT) begin
                    rd_data[rpfg_pkg::EV_W-1:0] <= ev_r;
                end else if (addr == rpfg_pkg::ADDR_MASK) begin
                    rd_data[rpfg_pkg::EV_W-1:0] <= mask_r;
                end else if (addr == rpfg_pkg::ADDR_COLL) begin
                    rd_data[rpfg_pkg::EVCNT_W-1:0] <= coll_cnt_r;
                end
            end
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    unstable_entry_a: assert property ((ci_r == rpfg_pkg::CI_STABLE && fce_hit) |=> ci_r == rpfg_pkg::CI_QUIET)
        else $error("false-carrier limit did not make port unstable");
    fce_clear_a: assert property (vc_rise |=> fce_cnt_r == '0)
        else $error("false-carrier count not cleared by valid carrier");
    jam_cap_a: assert property (gate.jam |-> $past(fc_len_r) < JAM_CYC && $past(fc))
        else $error("jam outside false carrier or past cap");
    unstable_gate_a: assert property (unstable |=> !gate.rx_pass && !gate.tx_pass)
        else $error("unstable port still passes messages");
    valid_exit_a: assert property ((ci_r == rpfg_pkg::CI_VALID && valid && !core.tx_active && ci_cnt_r >= VC_CYC)
        |=> ci_r == rpfg_pkg::CI_STABLE)
        else $error("valid carrier did not restore stable link");
    rate_block_a: assert property (!rate_ok |=> !gate.rx_pass)
        else $error("wrong-rate signal passed");
    part_entry_a: assert property ((pt_r == rpfg_pkg::PT_CLEAR && coll_cnt_r >= collision_event_limit)
        |=> pt_r == rpfg_pkg::PT_PART)
        else $error("collision limit did not partition");
    jab_part_a: assert property ((pt_r == rpfg_pkg::PT_CLEAR && jab_col) |=> pt_r == rpfg_pkg::PT_PART)
        else $error("long colliding reception did not partition");
    coll_incr_a: assert property ((tx_end && tx_col_r && !pt_release && coll_cnt_r != EVCNT_MAX)
        |=> coll_cnt_r == $past(coll_cnt_r) + 8'h01)
        else $error("colliding transmit not counted");
    coll_clear_a: assert property ((tx_end && !tx_col_r) |=> coll_cnt_r == '0)
        else $error("clean transmit did not clear collision count");
    part_tx_a: assert property ((parted && !unstable && !jabbing && ctrl_en_r)
        |=> gate.tx_pass && !gate.rx_pass)
        else $error("partitioned port gating wrong");
    jab_entry_a: assert property (jab_hit |=> jabbing ##1 (!gate.rx_pass && !gate.tx_pass))
        else $error("overlong reception not caught");
    jab_clear_a: assert property ((jabbing && !crs) |=> rt_r == rpfg_pkg::RT_IDLE)
        else $error("overlong state kept after carrier loss");

    relink_valid_c: cover property (ci_r == rpfg_pkg::CI_VALID ##1 ci_r == rpfg_pkg::CI_STABLE);
    part_release_c: cover property (pt_release ##1 pt_r == rpfg_pkg::PT_CLEAR);
    jab_seen_c: cover property (jabbing ##1 rt_r == rpfg_pkg::RT_IDLE);
    irq_seen_c: cover property (irq);

endmodule : rpfg_port_guard

// File: tb/rpfg_phy_model.sv
/* partner: PHY status pins and core status of one port
   assumes the bench calls its tasks from clock-aligned code */
`timescale 1ns/1ps
module rpfg_phy_model (
    input wire logic clk, // port clock
    output rpfg_pkg::rpfg_pins_t pins, // PHY status
    output rpfg_pkg::rpfg_core_t core // core status
);
    initial begin
        pins = '0;
        core = '0;
    end
    // levels change just after an edge
    task automatic rx(input logic c, input logic f, input logic r);
        @(posedge clk);
        pins <= '{crs: c, false_carrier: f & c, rate_ok: r};
    endtask : rx
    // one transmission of n cycles, colliding or clean
    task automatic tx(input int n, input logic k);
        @(posedge clk);
        core <= '{tx_active: 1'b1, collision: k};
        repeat (n) @(posedge clk);
        core <= '0;
    endtask : tx
endmodule : rpfg_phy_model

// File: tb/tb_repeater_port_fault_guard.sv
/* bench for the port fault guard: drives pins, core and register port
   assumes short timer parameters so the run stays brief */
`timescale 1ns/1ps
module tb_repeater_port_fault_guard;
    logic clk, rst_n, wr_en, rd_en, irq;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data;
    rpfg_pkg::rpfg_pins_t pins;
    rpfg_pkg::rpfg_core_t core;
    rpfg_pkg::rpfg_gate_t gate;
    int err_count, num_checks, cyc, seed, n;
    bit unst, part, jab, rate, en; // reference model
    rpfg_port_guard #(.false_carrier_event_limit(8'h02), .collision_event_limit(8'h03), .QUIET_BT(64),
        .VALID_CARRIER_BT(32), .JABBER_BT(400))
        rpfg_port_guard_i (.clk(clk), .rst_n(rst_n), .pins(pins), .core(core), .gate(gate), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq));
    rpfg_phy_model rpfg_phy_model_i (.clk(clk), .pins(pins), .core(core));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count = err_count + 1;
            conclude();
        end
    end
    task automatic conclude();
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        num_checks = num_checks + 1;
        if (got !== e) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, e);
        end
    endtask : chk
    // gates against the model, after pin sync has settled
    task automatic gates();
        repeat (6) @(posedge clk);
        #1;
        chk({gate.rx_pass, gate.tx_pass}, {en & !unst & !part & !jab & rate, en & !unst & !jab});
    endtask : gates
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data & m, e);
    endtask : rd
    initial begin
        seed = 32'h2497;
        rst_n = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        {unst, part, jab, rate, en} = 5'b10011;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rpfg_phy_model_i.rx(1'b0, 1'b0, 1'b1);
        gates();
        rd(rpfg_pkg::ADDR_STATE, 32'h1, 32'h1);
        repeat (30) @(posedge clk);
        unst = 0;
        gates();
        rd(rpfg_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
        wr(rpfg_pkg::ADDR_CTRL, 32'h0);
        en = 0;
        gates();
        wr(rpfg_pkg::ADDR_CTRL, 32'h1);
        en = 1;
        rpfg_phy_model_i.rx(1'b0, 1'b0, 1'b0);
        rate = 0;
        gates();
        rpfg_phy_model_i.rx(1'b0, 1'b0, 1'b1);
        rate = 1;
        wr(rpfg_pkg::ADDR_MASK, 32'h2);
        repeat (3) rpfg_phy_model_i.tx(4, 1'b1);
        part = 1;
        gates();
        chk(irq, 1'b1);
        rd(rpfg_pkg::ADDR_COLL, 32'hFF, 32'h3);
        rd(rpfg_pkg::ADDR_EVENT, 32'h2, 32'h2);
        @(posedge clk);
        #1;
        chk(irq, 1'b0);
        n = 1040 + ($random(seed) & 15);
        rpfg_phy_model_i.tx(n, 1'b0);
        part = 0;
        gates();
        rd(rpfg_pkg::ADDR_COLL, 32'hFF, 32'h0);
        rpfg_phy_model_i.rx(1'b1, 1'b0, 1'b1);
        repeat (120) @(posedge clk);
        jab = 1;
        gates();
        rpfg_phy_model_i.rx(1'b0, 1'b0, 1'b1);
        jab = 0;
        gates();
        for (n = 0; n < 2; n++) begin
            rpfg_phy_model_i.rx(1'b1, 1'b1, 1'b1);
            repeat (6) @(posedge clk);
            #1;
            if (n == 0) chk(gate.jam, 1'b1);
            repeat (4) @(posedge clk);
            rpfg_phy_model_i.rx(1'b0, 1'b0, 1'b1);
            repeat (8) @(posedge clk);
            #1;
            chk(gate.jam, 1'b0);
        end
        unst = 1;
        gates();
        repeat (30) @(posedge clk);
        unst = 0;
        gates();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        unst = 1;
        gates();
        // idle past the gap, then a valid carrier before the quiet exit
        repeat (19) @(posedge clk);
        rpfg_phy_model_i.rx(1'b1, 1'b0, 1'b1);
        repeat (14) @(posedge clk);
        unst = 0;
        gates();
        conclude();
    end
endmodule : tb_repeater_port_fault_guard
